//--- cpu_status_flags_bank_select.sv
// Processor status register with bank select, reset-cause and ALU flags.
// Assumes an AXI4-Lite master and synchronous core strobes on aclk.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module cpu_status_flags_bank_select
    import status_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address, data and response
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Core event strobes
    input  wire logic        watchdog_expire,
    input  wire logic        clear_watchdog_instr,
    input  wire logic        sleep,
    input  wire logic        alu_valid,
    input  wire logic [7:0]  alu_result,
    input  wire logic        alu_digit_carry,
    input  wire logic        alu_c,
    // Addressing, status and interrupt outputs
    output logic [8:0]       direct_bank_base,
    output logic             indirect_upper,
    output logic [7:0]       status_out,
    output logic             irq
);
    // =========================================================
    // Internal state
    logic [7:0]  status_q;      // Status register
    logic [2:0]  pwr_q;         // Power control status bits
    logic [3:0]  irq_stat_q;    // Sticky event bits
    logic [3:0]  irq_mask_q;    // Interrupt enables
    logic [3:0]  aw_q;          // Latched write address
    logic        aw_have_q;     // Write address held
    logic [31:0] w_q;           // Latched write data
    logic [3:0]  ws_q;          // Latched strobes
    logic        w_have_q;      // Write data held
    logic        wr_go;         // Write commits this cycle
    logic        wr_ok;         // Write address mapped
    logic        wr_lane0;      // Low byte written
    logic [3:0]  events;        // Event pulses

    flag_update_if fu ();
    assign fu.watchdog_expire      = watchdog_expire;
    assign fu.clear_watchdog_instr = clear_watchdog_instr;
    assign fu.sleep                = sleep;
    assign fu.alu_valid            = alu_valid;
    assign fu.alu_zero             = (alu_result == 8'h00);
    assign fu.alu_digit_carry      = alu_digit_carry;
    assign fu.alu_c                = alu_c;
    assign events                  = fu.events;

    // Event collector
    flag_events u_events (
        .fu (fu)
    );

    // =========================================================
    // Write channel capture
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign wr_go    = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_ok    = (aw_q == status_off) || (aw_q == pwr_ctl_off)
                   || (aw_q == irq_stat_off) || (aw_q == irq_mask_off);
    assign wr_lane0 = wr_go && ws_q[0];

    // Address and data latches
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_q      <= 4'h0;
            w_q       <= 32'h0000_0000;
            ws_q      <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                aw_q      <= s_axi_awaddr;
            end
            else if (wr_go)
                aw_have_q <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                w_q      <= s_axi_wdata;
                ws_q     <= s_axi_wstrb;
            end
            else if (wr_go)
                w_have_q <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= resp_okay;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? resp_okay : resp_slverr;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // =========================================================
    // Status register: bank bits software, reset-cause bits hardware
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            status_q <= status_rst;  // Flags set at power-up
        else
        begin
            // Software writes bank and ALU bits; flag bits are read-only
            if (wr_lane0 && aw_q == status_off)
            begin
                status_q[indirect_bank_pos] <= w_q[indirect_bank_pos];
                status_q[bank_sel_hi_pos]   <= w_q[bank_sel_hi_pos];
                status_q[bank_sel_lo_pos]   <= w_q[bank_sel_lo_pos];
                status_q[zero_pos]          <= w_q[zero_pos];
                status_q[digit_carry_pos]   <= w_q[digit_carry_pos];
                status_q[carry_pos]         <= w_q[carry_pos];
            end
            // ALU update outranks a software write
            if (alu_valid)
            begin
                status_q[zero_pos]        <= fu.alu_zero;
                status_q[digit_carry_pos] <= alu_digit_carry;
                status_q[carry_pos]       <= alu_c;
            end
            // Timeout flag
            if (clear_watchdog_instr || sleep)
                status_q[timeout_pos] <= 1'b1;
            else if (watchdog_expire)
                status_q[timeout_pos] <= 1'b0;
            // Power-down flag
            if (clear_watchdog_instr)
                status_q[power_down_pos] <= 1'b1;
            else if (sleep)
                status_q[power_down_pos] <= 1'b0;
        end
    end

    // Power control status bits, loaded with pwr_ctl_rst (bit 2 set) at power-up, written by software
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pwr_q <= pwr_ctl_rst;
        else if (wr_lane0 && aw_q == pwr_ctl_off)
            pwr_q <= w_q[2:0];
    end

    // =========================================================
    // Interrupt status and mask; set wins over write-one-clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_stat_q <= irq_rst;
        else if (wr_lane0 && aw_q == irq_stat_off)
            irq_stat_q <= (irq_stat_q & ~w_q[3:0]) | events;
        else
            irq_stat_q <= irq_stat_q | events;
    end

    // Mask register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_mask_q <= irq_rst;
        else if (wr_lane0 && aw_q == irq_mask_off)
            irq_mask_q <= w_q[3:0];
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // =========================================================
    // Read channel, one-cycle answer
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= resp_okay;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= resp_okay;
            unique case (s_axi_araddr)
                status_off:   s_axi_rdata <= {24'h000000, status_q};
                // Reset-cause bits side by side
                pwr_ctl_off:  s_axi_rdata <= {24'h000000, status_q[timeout_pos],
                                              status_q[power_down_pos], 3'h0, pwr_q};
                irq_stat_off: s_axi_rdata <= {28'h0000000, irq_stat_q};
                irq_mask_off: s_axi_rdata <= {28'h0000000, irq_mask_q};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= resp_slverr;
                end
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // =========================================================
    // Bank decode outputs
    assign direct_bank_base = status_q[bank_sel_hi_pos] ?
        (status_q[bank_sel_lo_pos] ? 9'(3 * bank_span) : 9'(2 * bank_span)) :
        (status_q[bank_sel_lo_pos] ? bank_span : 9'h000);
    assign indirect_upper   = status_q[indirect_bank_pos];
    assign status_out       = status_q;

    // =========================================================
    // Assertions
    sequence expire_only_s;
        watchdog_expire && !clear_watchdog_instr && !sleep;
    endsequence

    sequence sleep_s;
        sleep && !clear_watchdog_instr;
    endsequence

    timeout_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        expire_only_s |=> !status_q[timeout_pos])
        else $error("timeout flag not cleared by expiry");
    timeout_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (clear_watchdog_instr || sleep) |=> status_q[timeout_pos])
        else $error("timeout flag not set");
    power_down_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        clear_watchdog_instr |=> status_q[power_down_pos])
        else $error("power-down flag not set");
    power_down_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
        sleep_s |=> !status_q[power_down_pos])
        else $error("power-down flag not cleared by sleep");
    zero_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        alu_valid |=> status_q[zero_pos] == ($past(alu_result) == 8'h00))
        else $error("zero flag wrong");
    bank_decode_a: assert property (@(posedge aclk) disable iff (!aresetn)
        direct_bank_base == 9'({status_q[bank_sel_hi_pos], status_q[bank_sel_lo_pos]}
                               * bank_span))
        else $error("bank base wrong");
    // Software write of the indirect bit reaches the pair select output
    indirect_pair_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (wr_lane0 && aw_q == status_off) |=> indirect_upper == $past(w_q[indirect_bank_pos]))
        else $error("indirect pair wrong");
    reset_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == pwr_ctl_off)
        |=> s_axi_rdata[7:6] == $past({status_q[timeout_pos], status_q[power_down_pos]}))
        else $error("reset cause read wrong");
endmodule // cpu_status_flags_bank_select

//--- status_pkg.sv
// Package for the processor status flag register block.
// Assumes an AXI4-Lite slave with 32-bit data and one clock.
package status_pkg;
    // =========================================================
    // Register byte offsets
    localparam logic [3:0] status_off    = 4'h0;
    localparam logic [3:0] pwr_ctl_off   = 4'h4;
    localparam logic [3:0] irq_stat_off  = 4'h8;
    localparam logic [3:0] irq_mask_off  = 4'hC;
    // =========================================================
    // Status register field positions
    localparam int indirect_bank_pos  = 7;
    localparam int bank_sel_hi_pos    = 6;
    localparam int bank_sel_lo_pos    = 5;
    localparam int timeout_pos        = 4;
    localparam int power_down_pos     = 3;
    localparam int zero_pos           = 2;
    localparam int digit_carry_pos    = 1;
    localparam int carry_pos          = 0;
    // Power control status fields
    localparam int parity_ok_pos      = 2;
    localparam int por_ok_pos         = 1;
    localparam int bor_ok_pos         = 0;
    // =========================================================
    // Reset values and sizes
    localparam logic [7:0] status_rst   = 8'h18;
    localparam logic [2:0] pwr_ctl_rst  = 3'h4;
    localparam logic [3:0] irq_rst      = 4'h0;
    localparam logic [8:0] bank_span    = 9'h080;
    // Interrupt event bits
    localparam int ev_timeout  = 0;
    localparam int ev_sleep    = 1;
    localparam int ev_clear_watchdog = 2;
    localparam int ev_zero     = 3;
    localparam logic [1:0] resp_okay   = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage

//--- flag_update_if.sv
// Interface carrying flag-update events into the status register.
// Assumes all signals are single-cycle pulses on aclk.
`timescale 1ns/1ps
interface flag_update_if;
    logic       watchdog_expire;       // Watchdog timer expiry pulse
    logic       clear_watchdog_instr;  // Clear-watchdog instruction pulse
    logic       sleep;                 // Sleep instruction pulse
    logic       alu_valid;             // Arithmetic result valid
    logic       alu_zero;              // Result equals zero
    logic       alu_digit_carry;       // Digit carry from ALU
    logic       alu_c;                 // Carry from ALU
    logic [3:0] events;                // Event pulses for interrupt status
    modport src (output watchdog_expire, clear_watchdog_instr, sleep, alu_valid,
                 alu_zero, alu_digit_carry, alu_c, input events);
    modport dst (input watchdog_expire, clear_watchdog_instr, sleep, alu_valid,
                 alu_zero, alu_digit_carry, alu_c, output events);
endinterface // flag_update_if

//--- flag_events.sv
// Event collector: turns instruction and ALU strobes into event pulses.
// Assumes inputs are synchronous to aclk.
`timescale 1ns/1ps
module flag_events
    import status_pkg::*;
(
    // Event bundle
    flag_update_if.dst fu
);
    // =========================================================
    // Event vector for interrupt status
    always_comb
    begin
        fu.events               = '0;
        fu.events[ev_timeout]        = fu.watchdog_expire;
        fu.events[ev_sleep]          = fu.sleep;
        fu.events[ev_clear_watchdog] = fu.clear_watchdog_instr;
        fu.events[ev_zero]      = fu.alu_valid & fu.alu_zero;
    end
endmodule // flag_events

//--- cpu_status_flags_bank_select_tb_top.sv
// Self-checking bench for the status flag register block.
// Assumes status_pkg and the design files are compiled before it.
`timescale 1ns/1ps
module cpu_status_flags_bank_select_tb_top;
    import status_pkg::*;
    // =========================================================
    // Signals
    logic        aclk, aresetn;                  // Clock and reset
    logic [3:0]  awaddr, araddr, wstrb;          // Address and strobes
    logic        awvalid, wvalid, bready;        // Write handshake
    logic        arvalid, rready;                // Read handshake
    logic        awready, wready, bvalid;        // Write answers
    logic        arready, rvalid;                // Read answers
    logic [31:0] wdata, rdata, seen_q;           // Data words
    logic [1:0]  bresp, rresp, resp_q;           // Response codes
    logic [2:0]  ev;                             // Expiry, clear-watchdog, sleep
    logic        alu_valid, alu_digit_carry, alu_c; // ALU strobe and carries
    logic [7:0]  alu_result;                     // ALU result byte
    logic [8:0]  direct_bank_base;               // Bank base out
    logic        indirect_upper, irq;            // Pair select, interrupt
    logic [7:0]  status_out;                     // Status mirror
    int          fail_count, n_compared;         // Tallies
    // =========================================================
    // Design under test
    cpu_status_flags_bank_select dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .watchdog_expire(ev[0]), .clear_watchdog_instr(ev[1]), .sleep(ev[2]),
        .alu_valid(alu_valid), .alu_result(alu_result),
        .alu_digit_carry(alu_digit_carry),
        .alu_c(alu_c), .direct_bank_base(direct_bank_base),
        .indirect_upper(indirect_upper), .status_out(status_out), .irq(irq)
    );
    // =========================================================
    // Clock, 100 ns period
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // =========================================================
    // Closing report
    task automatic give_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Compare seen against expected
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            fail_count++;
        end
    endtask
    // =========================================================
    // AXI4-Lite write, both channels offered together
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er = resp_okay);
        logic aw_done, w_done;
        begin
            aw_done = 1'b0;
            w_done  = 1'b0;
            awaddr  <= a;
            wdata   <= d;
            wstrb   <= s;
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            bready  <= 1'b1;
            for (int n = 0; n < 50; n++)
            begin
                @(posedge aclk);
                if (aw_done && w_done && bvalid)
                begin
                    bready <= 1'b0;
                    chk("bresp", 32'(bresp), 32'(er));
                    // Let an edge pass before the next call raises bready
                    @(posedge aclk);
                    return;
                end
                if (!aw_done && awready)
                begin
                    aw_done = 1'b1;
                    awvalid <= 1'b0;
                end
                if (!w_done && wready)
                begin
                    w_done = 1'b1;
                    wvalid <= 1'b0;
                end
            end
            fail_count++;
            give_verdict();
        end
    endtask
    // AXI4-Lite read into seen_q and resp_q
    task automatic rd(input logic [3:0] a);
        logic taken;
        begin
            taken   = 1'b0;
            araddr  <= a;
            arvalid <= 1'b1;
            rready  <= 1'b1;
            for (int n = 0; n < 50; n++)
            begin
                @(posedge aclk);
                if (taken && rvalid)
                begin
                    seen_q = rdata;
                    resp_q = rresp;
                    rready <= 1'b0;
                    // Let an edge pass before the next call raises rready
                    @(posedge aclk);
                    return;
                end
                if (!taken && arready)
                begin
                    taken = 1'b1;
                    arvalid <= 1'b0;
                end
            end
            fail_count++;
            give_verdict();
        end
    endtask
    // Read one register and compare its word
    task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] exp);
        rd(a);
        chk(nm, seen_q, exp);
        chk("rresp", 32'(resp_q), 32'(resp_okay));
    endtask
    // One-cycle pulse on the event strobes
    task automatic pulse(input logic [2:0] m);
        ev <= m;
        @(posedge aclk);
        ev <= 3'h0;
        @(posedge aclk);
    endtask
    // One ALU result beat
    task automatic alu(input logic [7:0] res, input logic digit_carry, input logic c);
        alu_valid       <= 1'b1;
        alu_result      <= res;
        alu_digit_carry <= digit_carry;
        alu_c      <= c;
        @(posedge aclk);
        alu_valid <= 1'b0;
        @(posedge aclk);
    endtask
    // Reset held for four cycles
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    // =========================================================
    // Main sequence
    initial
    begin
        {aresetn, awaddr, araddr, wstrb, awvalid, wvalid, bready} = '0;
        {arvalid, rready, wdata, ev, alu_valid, alu_result, alu_digit_carry, alu_c} = '0;
        fail_count = 0;
        n_compared = 0;
        do_reset();
        rchk("status", status_off, 32'h18);
        rchk("pwr_ctl", pwr_ctl_off, 32'hC4);
        rchk("irq_stat", irq_stat_off, 32'h0);
        // Every direct bank encoding
        for (int i = 0; i < 4; i++)
        begin
            wr(status_off, 32'(i) << 5, 4'hF);
            rchk("status", status_off, (32'(i) << 5) | 32'h18);
            chk("bank_base", 32'(direct_bank_base), 32'(i) * 32'h80);
            chk("indirect", 32'(indirect_upper), 32'h0);
        end
        wr(status_off, 32'h80, 4'hF);
        chk("indirect", 32'(indirect_upper), 32'h1);
        chk("bank_base", 32'(direct_bank_base), 32'h0);
        wr(status_off, 32'h60, 4'h0);
        rchk("status", status_off, 32'h98);
        // Watchdog expiry and the interrupt path
        pulse(3'b001);
        rchk("status", status_off, 32'h88);
        chk("status_out", 32'(status_out), 32'h88);
        rchk("pwr_ctl", pwr_ctl_off, 32'h44);
        rchk("irq_stat", irq_stat_off, 32'h1);
        chk("irq", 32'(irq), 32'h0);
        wr(irq_mask_off, 32'hF, 4'hF);
        chk("irq", 32'(irq), 32'h1);
        wr(irq_stat_off, 32'h1, 4'hF);
        rchk("irq_stat", irq_stat_off, 32'h0);
        chk("irq", 32'(irq), 32'h0);
        // Clear-watchdog then sleep
        pulse(3'b010);
        rchk("status", status_off, 32'h98);
        pulse(3'b100);
        rchk("status", status_off, 32'h90);
        rchk("pwr_ctl", pwr_ctl_off, 32'h84);
        // Zero and non-zero results
        alu(8'h00, 1'b1, 1'b0);
        rchk("status", status_off, 32'h96);
        rchk("irq_stat", irq_stat_off, 32'hE);
        alu(8'h05, 1'b0, 1'b1);
        rchk("status", status_off, 32'h91);
        wr(irq_stat_off, 32'hF, 4'hF);
        chk("irq", 32'(irq), 32'h0);
        // Software cannot touch the reset-cause flags
        wr(status_off, 32'h07, 4'hF);
        rchk("status", status_off, 32'h17);
        // Power control bits writable, reset-cause bits beside them are not
        wr(pwr_ctl_off, 32'hFF, 4'hF);
        rchk("pwr_ctl", pwr_ctl_off, 32'h87);
        // Misaligned address is refused on both paths
        wr(4'h2, 32'hFF, 4'hF, resp_slverr);
        rchk("status", status_off, 32'h17);
        rd(4'h2);
        chk("rresp", 32'(resp_q), 32'(resp_slverr));
        chk("rdata", seen_q, 32'h0);
        // Second reset mid-run
        do_reset();
        rchk("status", status_off, 32'h18);
        rchk("pwr_ctl", pwr_ctl_off, 32'hC4);
        give_verdict();
    end
endmodule // cpu_status_flags_bank_select_tb_top
